// ---- shared/cvr_cfg.svh ----
// Offsets, field positions, reset values and codes of the comparator/reference bank

`ifndef CVR_CFG_SVH
`define CVR_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CVR_OFS_CMP   8'h00
`define CVR_OFS_REF   8'h04
`define CVR_OFS_STAT  8'h08
`define CVR_OFS_MASK  8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CVR_CMP_RES2   7
`define CVR_CMP_RES1   6
`define CVR_CMP_INV2   5
`define CVR_CMP_INV1   4
`define CVR_CMP_SWITCH 3
`define CVR_REF_EN     7
`define CVR_REF_OE     6
`define CVR_REF_RANGE  5
`define CVR_REF_SRC    4
`define CVR_STAT_CHG   0

// ----------------------------------------
// Reset values and mode codes
// ----------------------------------------
`define CVR_CMP_RESET  6'h07
`define CVR_REF_RESET  8'h00
`define CVR_MODE_OFF   3'b111
`define CVR_MODE_REF   3'b110

`endif

// ---- shared/cvr_pkg.sv ----
// Types shared by the comparator/reference control bank
package cvr_pkg;

  // ----------------------------------------
  // Bus response codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CVR_RESP_OKAY   = 2'b00,
    CVR_RESP_SLVERR = 2'b10
  } cvr_resp_type;

  // ----------------------------------------
  // Register select, one-hot
  // ----------------------------------------
  typedef enum logic [4:0] {
    CVR_SEL_CMP  = 5'b00001,
    CVR_SEL_REF  = 5'b00010,
    CVR_SEL_STAT = 5'b00100,
    CVR_SEL_MASK = 5'b01000,
    CVR_SEL_NONE = 5'b10000
  } cvr_sel_type;

  // ----------------------------------------
  // Synchroniser state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } cvr_sync_state_type;

  // ----------------------------------------
  // Bank state
  // ----------------------------------------
  typedef struct packed {
    logic [5:0]   cmp_cfg;
    logic [7:0]   ref_ctl;
    logic [1:0]   result;
    logic [1:0]   snap;
    logic         chg_flag;
    logic         chg_mask;
    logic         aw_got;
    logic [7:0]   aw_addr;
    logic         w_got;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         b_valid;
    cvr_resp_type b_resp;
    logic         r_valid;
    logic [31:0]  r_data;
    cvr_resp_type r_resp;
  } cvr_state_type;

endpackage : cvr_pkg

// ---- hdl/cvr_sync2.sv ----
// Two-stage synchroniser for the two raw comparator outputs
`timescale 1ns/1ps

module cvr_sync2
  import cvr_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] async_i,
  output logic      [1:0] sync_o
);

  cvr_sync_state_type q;
  cvr_sync_state_type d;

  // Second stage reads only the first
  always_comb begin
    d        = q;
    d.meta   = async_i;
    d.stable = q.meta;
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign sync_o = q.stable;

endmodule : cvr_sync2

// ---- hdl/cvr_tap_decode.sv ----
// One-hot ladder tap decode from range and level
`timescale 1ns/1ps

module cvr_tap_decode
  import cvr_pkg::*;
(
  input  wire logic        enable_i,
  input  wire logic        range_i,
  input  wire logic [3:0]  level_i,
  output logic      [31:0] taps_o
);

  // One bit set at the given index
  function automatic logic [31:0] cvr_onehot(input logic [4:0] idx);
    logic [31:0] v;
    v      = 32'h0000_0000;
    v[idx] = 1'b1;
    return v;
  endfunction : cvr_onehot

  // Low range taps 16..31, high range taps 0..15
  always_comb begin
    if (enable_i) begin
      taps_o = cvr_onehot({~range_i, level_i});
    end else begin
      taps_o = 32'h0000_0000;
    end
  end

endmodule : cvr_tap_decode

// ---- hdl/cvr_comparator_vref_ctrl.sv ----
// Comparator and voltage reference control bank with AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "cvr_cfg.svh"

module cvr_comparator_vref_ctrl
  import cvr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // Write response channel
  output logic      [1:0]  s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  // Read data channel
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Analog comparator side
  input  wire logic        first_cmp_raw_i,
  input  wire logic        second_cmp_raw_i,
  output logic      [2:0]  comparator_mode_field_o,
  output logic             comparators_on_o,
  output logic             input_switch_o,
  output logic             ref_to_noninv_o,
  output logic             first_comparator_result_o,
  output logic             second_comparator_result_o,
  // Reference ladder side
  output logic             reference_enable_o,
  output logic             reference_pin_output_enable_o,
  output logic             reference_range_select_o,
  output logic             reference_source_select_o,
  output logic      [3:0]  reference_level_select_o,
  output logic      [31:0] ladder_tap_select_o,
  // Shared pin direction
  input  wire logic        port_direction_control_i,
  output logic             reference_pin_digital_oe_o,
  // Sleep, wake and interrupt
  input  wire logic        sleep_i,
  output logic             wake_o,
  output logic             irq_o,
  output logic             comparator_change_flag_o
);

  // ----------------------------------------
  // Reset image
  // ----------------------------------------

  // Comparators off, reference cleared
  localparam cvr_state_type CVR_RESET_STATE = '{
    cmp_cfg:  `CVR_CMP_RESET,
    ref_ctl:  `CVR_REF_RESET,
    result:   2'b00,
    snap:     2'b00,
    chg_flag: 1'b0,
    chg_mask: 1'b0,
    aw_got:   1'b0,
    aw_addr:  8'h00,
    w_got:    1'b0,
    w_data:   32'h0000_0000,
    w_strb:   4'h0,
    b_valid:  1'b0,
    b_resp:   CVR_RESP_OKAY,
    r_valid:  1'b0,
    r_data:   32'h0000_0000,
    r_resp:   CVR_RESP_OKAY
  };

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Byte address to register select
  function automatic cvr_sel_type cvr_decode(input logic [7:0] addr);
    cvr_sel_type s;
    case (addr)
      `CVR_OFS_CMP: begin
        s = CVR_SEL_CMP;
      end
      `CVR_OFS_REF: begin
        s = CVR_SEL_REF;
      end
      `CVR_OFS_STAT: begin
        s = CVR_SEL_STAT;
      end
      `CVR_OFS_MASK: begin
        s = CVR_SEL_MASK;
      end
      default: begin
        s = CVR_SEL_NONE;
      end
    endcase
    return s;
  endfunction : cvr_decode

  // ----------------------------------------
  // Declarations
  // ----------------------------------------

  cvr_state_type q;
  cvr_state_type d;
  logic [1:0]    raw_sync;
  logic          cmp_on;
  logic          mismatch;
  logic          aw_hs;
  logic          w_hs;
  logic          ar_hs;
  logic          wr_fire;
  logic          flag_clr;
  cvr_sel_type   wr_sel;
  cvr_sel_type   rd_sel;
  logic [7:0]    cmp_word;

  // ----------------------------------------
  // Raw comparator inputs
  // ----------------------------------------

  // Analog outputs are asynchronous to the bank clock
  cvr_sync2 u_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .async_i   ({second_cmp_raw_i, first_cmp_raw_i}),
    .sync_o    (raw_sync)
  );

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------

  // Address and data held until both arrive
  assign s_axi_awready_o = ce_i & ~q.aw_got & ~q.b_valid;
  assign s_axi_wready_o  = ce_i & ~q.w_got & ~q.b_valid;
  assign s_axi_arready_o = ce_i & ~q.r_valid;

  // Transfer strobes
  assign aw_hs   = s_axi_awvalid_i & s_axi_awready_o;
  assign w_hs    = s_axi_wvalid_i & s_axi_wready_o;
  assign ar_hs   = s_axi_arvalid_i & s_axi_arready_o;
  assign wr_fire = q.aw_got & q.w_got;

  // Decoded targets
  assign wr_sel = cvr_decode(q.aw_addr);
  assign rd_sel = cvr_decode(s_axi_araddr_i);

  // ----------------------------------------
  // Comparator status
  // ----------------------------------------

  // Mode 111 powers both comparators down
  assign cmp_on   = (q.cmp_cfg[2:0] != `CVR_MODE_OFF);
  // Live results differ from the last value software saw
  assign mismatch = (q.result != q.snap);

  // Readback view of the comparator register
  assign cmp_word = {q.result[1], q.result[0], q.cmp_cfg};

  // Write-one-to-clear of the change flag
  assign flag_clr = wr_fire & (wr_sel == CVR_SEL_STAT) & q.w_strb[0]
                    & q.w_data[`CVR_STAT_CHG];

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  always_comb begin
    d = q;

    // Results keep tracking in sleep; inversion applied here
    if (cmp_on) begin
      d.result = raw_sync ^ {q.cmp_cfg[`CVR_CMP_INV2], q.cmp_cfg[`CVR_CMP_INV1]};
    end else begin
      d.result = 2'b00;
    end

    // Capture write address
    if (aw_hs) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr_i;
    end

    // Capture write data
    if (w_hs) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata_i;
      d.w_strb = s_axi_wstrb_i;
    end

    // Write response taken
    if (q.b_valid && s_axi_bready_i) begin
      d.b_valid = 1'b0;
    end

    // Perform the write once both halves are in
    if (wr_fire) begin
      d.aw_got  = 1'b0;
      d.w_got   = 1'b0;
      d.b_valid = 1'b1;
      d.b_resp  = (wr_sel == CVR_SEL_NONE) ? CVR_RESP_SLVERR : CVR_RESP_OKAY;
      case (wr_sel)
        CVR_SEL_CMP: begin
          // Any write ends the mismatch
          d.snap = q.result;
          if (q.w_strb[0]) begin
            d.cmp_cfg = q.w_data[5:0];
          end
        end
        CVR_SEL_REF: begin
          if (q.w_strb[0]) begin
            d.ref_ctl = q.w_data[7:0];
          end
        end
        CVR_SEL_MASK: begin
          if (q.w_strb[0]) begin
            d.chg_mask = q.w_data[`CVR_STAT_CHG];
          end
        end
        CVR_SEL_STAT: begin
          d.chg_mask = q.chg_mask;
        end
        default: begin
          d.b_resp = CVR_RESP_SLVERR;
        end
      endcase
    end

    // Sticky change flag, a new change beats the clear
    d.chg_flag = mismatch | (q.chg_flag & ~flag_clr);

    // Read data taken
    if (q.r_valid && s_axi_rready_i) begin
      d.r_valid = 1'b0;
    end

    // Read request
    if (ar_hs) begin
      d.r_valid = 1'b1;
      d.r_resp  = CVR_RESP_OKAY;
      case (rd_sel)
        CVR_SEL_CMP: begin
          d.r_data = {24'h00_0000, cmp_word};
          // Reading also ends the mismatch
          d.snap   = q.result;
        end
        CVR_SEL_REF: begin
          d.r_data = {24'h00_0000, q.ref_ctl};
        end
        CVR_SEL_STAT: begin
          d.r_data = {31'h0000_0000, q.chg_flag};
        end
        CVR_SEL_MASK: begin
          d.r_data = {31'h0000_0000, q.chg_mask};
        end
        default: begin
          d.r_data = 32'h0000_0000;
          d.r_resp = CVR_RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Only reset clears the fields; sleep and wake never touch them
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      q <= CVR_RESET_STATE;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Bus outputs
  // ----------------------------------------

  assign s_axi_bvalid_o = q.b_valid;
  assign s_axi_bresp_o  = q.b_resp;
  assign s_axi_rvalid_o = q.r_valid;
  assign s_axi_rresp_o  = q.r_resp;
  assign s_axi_rdata_o  = q.r_data;

  // ----------------------------------------
  // Comparator controls
  // ----------------------------------------

  assign comparator_mode_field_o    = q.cmp_cfg[2:0];
  assign comparators_on_o           = cmp_on;
  assign input_switch_o             = q.cmp_cfg[`CVR_CMP_SWITCH];
  // Internal reference only in the multiplexed mode
  assign ref_to_noninv_o            = (q.cmp_cfg[2:0] == `CVR_MODE_REF);
  assign first_comparator_result_o  = q.result[0];
  assign second_comparator_result_o = q.result[1];

  // ----------------------------------------
  // Reference controls
  // ----------------------------------------

  assign reference_enable_o            = q.ref_ctl[`CVR_REF_EN];
  assign reference_pin_output_enable_o = q.ref_ctl[`CVR_REF_OE];
  assign reference_range_select_o      = q.ref_ctl[`CVR_REF_RANGE];
  assign reference_source_select_o     = q.ref_ctl[`CVR_REF_SRC];
  assign reference_level_select_o      = q.ref_ctl[3:0];

  // Ladder tap picker
  cvr_tap_decode u_taps (
    .enable_i (q.ref_ctl[`CVR_REF_EN]),
    .range_i  (q.ref_ctl[`CVR_REF_RANGE]),
    .level_i  (q.ref_ctl[3:0]),
    .taps_o   (ladder_tap_select_o)
  );

  // Reference routing turns the pin's digital driver off
  assign reference_pin_digital_oe_o = ~q.ref_ctl[`CVR_REF_OE]
                                      & ~port_direction_control_i;

  // ----------------------------------------
  // Interrupt and wake
  // ----------------------------------------

  assign comparator_change_flag_o = q.chg_flag;
  assign irq_o                    = q.chg_flag & q.chg_mask;
  // Enabled interrupt wakes the sleeping device
  assign wake_o                   = sleep_i & q.chg_flag & q.chg_mask;

endmodule : cvr_comparator_vref_ctrl

// ---- verification/cvr_props.sv ----
// Port-level properties of the comparator/reference control bank
`timescale 1ns/1ps

module cvr_props (
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic [2:0]  comparator_mode_field_o,
  input wire logic        ref_to_noninv_o,
  input wire logic        first_comparator_result_o,
  input wire logic        second_comparator_result_o,
  input wire logic        reference_enable_o,
  input wire logic        reference_pin_output_enable_o,
  input wire logic        reference_range_select_o,
  input wire logic [3:0]  reference_level_select_o,
  input wire logic [31:0] ladder_tap_select_o,
  input wire logic        reference_pin_digital_oe_o,
  input wire logic        sleep_i,
  input wire logic        wake_o,
  input wire logic        irq_o,
  input wire logic        comparator_change_flag_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Tap index from range and level
  wire logic [4:0] tap_idx = {~reference_range_select_o, reference_level_select_o};

  cmp_reset_a: assert property ($past(sys_rst_i) |-> comparator_mode_field_o == 3'h7)
    else $error("comparator mode not off after reset");
  ref_reset_a: assert property ($past(sys_rst_i) |-> !reference_enable_o
    && !reference_pin_output_enable_o && !reference_range_select_o
    && reference_level_select_o == 4'h0) else $error("reference fields not cleared by reset");
  tap_onehot_a: assert property (reference_enable_o
    |-> ladder_tap_select_o == (32'h1 << tap_idx)) else $error("ladder tap wrong");
  tap_off_a: assert property (!reference_enable_o |-> ladder_tap_select_o == 32'h0)
    else $error("ladder tap driven while reference off");
  ref_route_a: assert property (ref_to_noninv_o == (comparator_mode_field_o == 3'h6))
    else $error("reference routing disagrees with mode");
  pin_route_a: assert property (reference_pin_output_enable_o
    |-> !reference_pin_digital_oe_o) else $error("pin driven while reference routed");
  wake_irq_a: assert property (sleep_i && irq_o |-> wake_o)
    else $error("no wake on pending interrupt");
  chg_flag_a: assert property ($changed({first_comparator_result_o,
    second_comparator_result_o}) |=> comparator_change_flag_o) else $error("change flag missed");
  wake_hold_a: assert property ($fell(sleep_i) && !s_axi_bvalid_o
    |-> $stable({comparator_mode_field_o, reference_enable_o, reference_range_select_o,
    reference_level_select_o})) else $error("fields changed on wake");
  irq_flag_a: assert property (irq_o |-> comparator_change_flag_o)
    else $error("interrupt without flag");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");

  wake_c: cover property (wake_o);
  irq_c: cover property (irq_o);
  low_range_c: cover property (reference_enable_o && !reference_range_select_o);
endmodule : cvr_props

bind cvr_comparator_vref_ctrl cvr_props i_props (.*);

// ---- verification/test_cvr_comparator_vref_ctrl.sv ----
// Self-checking bench for the comparator/reference control bank
`timescale 1ns/1ps
`include "cvr_cfg.svh"

module test_cvr_comparator_vref_ctrl
  import cvr_pkg::*;
;
  // ----------------------------------------
  // Stimulus, results and instance
  // ----------------------------------------
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic [7:0]  s_axi_awaddr_i = 8'h00;
  logic        s_axi_awvalid_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic        s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0;
  logic [7:0]  s_axi_araddr_i = 8'h00;
  logic        s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  logic        first_cmp_raw_i = 1'b0;
  logic        second_cmp_raw_i = 1'b0;
  logic        port_direction_control_i = 1'b1;
  logic        sleep_i = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o, ladder_tap_select_o;
  logic [2:0]  comparator_mode_field_o;
  logic [3:0]  reference_level_select_o;
  logic        comparators_on_o, input_switch_o, ref_to_noninv_o, first_comparator_result_o;
  logic        second_comparator_result_o, reference_enable_o, reference_pin_output_enable_o;
  logic        reference_range_select_o, reference_source_select_o, reference_pin_digital_oe_o;
  logic        wake_o, irq_o, comparator_change_flag_o;
  int          err_count = 0;
  int          checks_done = 0;

  cvr_comparator_vref_ctrl i_dut (.*);

  // Clock and watchdog
  always #50 ref_clk_i = ~ref_clk_i;
  initial begin
    #500000;
    err_count++;
    give_verdict();
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // Bus write: offer address and data, hold each until taken, wait for response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      // Response left waiting one cycle so its hold is exercised
      if (s_axi_bvalid_o && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
    end while (!(s_axi_bvalid_o && s_axi_bready_i) && n < 40);
    s_axi_bready_i <= 1'b0;
    cmp("write answer", 32'h1, 32'(s_axi_bvalid_o & s_axi_bready_i));
    cmp("write response", 32'(er), 32'(s_axi_bresp_o));
  endtask : wr

  // Bus read with data and response judged
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o && n < 40);
    s_axi_rready_i <= 1'b0;
    cmp("read answer", 32'h1, 32'(s_axi_rvalid_o));
    cmp("read data", ed, s_axi_rdata_o);
    cmp("read response", 32'(er), 32'(s_axi_rresp_o));
  endtask : rd

  task automatic t_reset;
    rd(`CVR_OFS_CMP, 32'h07, CVR_RESP_OKAY);
    rd(`CVR_OFS_REF, 32'h00, CVR_RESP_OKAY);
    cmp("taps", 32'h0, ladder_tap_select_o);
  endtask : t_reset

  // Every range/source pair at both level extremes
  task automatic t_ladder;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {2'b10, i[0], i[1], {4{i[2]}}};
      wr(`CVR_OFS_REF, {24'h0, v}, CVR_RESP_OKAY);
      rd(`CVR_OFS_REF, {24'h0, v}, CVR_RESP_OKAY);
      cmp("range", 32'(i[0]), 32'(reference_range_select_o));
      cmp("source", 32'(i[1]), 32'(reference_source_select_o));
      cmp("enable", 32'h1, 32'(reference_enable_o));
      cmp("tap", 32'h1 << {~i[0], {4{i[2]}}}, ladder_tap_select_o);
    end
    wr(`CVR_OFS_REF, 32'h09, CVR_RESP_OKAY);
    cmp("taps off", 32'h0, ladder_tap_select_o);
  endtask : t_ladder

  task automatic t_pin;
    wr(`CVR_OFS_REF, 32'h40, CVR_RESP_OKAY);
    port_direction_control_i <= 1'b0;
    @(posedge ref_clk_i);
    cmp("pin oe routed", 32'h0, 32'(reference_pin_digital_oe_o));
    wr(`CVR_OFS_REF, 32'h00, CVR_RESP_OKAY);
    cmp("pin oe free", 32'h1, 32'(reference_pin_digital_oe_o));
  endtask : t_pin

  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      wr(`CVR_OFS_CMP, 32'(m), CVR_RESP_OKAY);
      cmp("noninv", 32'(m == 6), 32'(ref_to_noninv_o));
      cmp("on", 32'(m != 7), 32'(comparators_on_o));
    end
  endtask : t_modes

  // Result changes with and without the interrupt unmasked
  task automatic t_flag;
    wr(`CVR_OFS_CMP, 32'h00, CVR_RESP_OKAY);
    wr(`CVR_OFS_MASK, 32'h1, CVR_RESP_OKAY);
    first_cmp_raw_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    cmp("flag", 32'h1, 32'(comparator_change_flag_o));
    cmp("irq", 32'h1, 32'(irq_o));
    cmp("first result", 32'h1, 32'(first_comparator_result_o));
    sleep_i <= 1'b1;
    @(posedge ref_clk_i);
    cmp("wake", 32'h1, 32'(wake_o));
    sleep_i <= 1'b0;
    rd(`CVR_OFS_CMP, 32'h40, CVR_RESP_OKAY);
    wr(`CVR_OFS_STAT, 32'h1, CVR_RESP_OKAY);
    cmp("flag cleared", 32'h0, 32'(comparator_change_flag_o));
    wr(`CVR_OFS_MASK, 32'h0, CVR_RESP_OKAY);
    second_cmp_raw_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    cmp("masked irq", 32'h0, 32'(irq_o));
    cmp("second result", 32'h1, 32'(second_comparator_result_o));
    rd(`CVR_OFS_STAT, 32'h1, CVR_RESP_OKAY);
  endtask : t_flag

  task automatic t_sleep;
    wr(`CVR_OFS_CMP, 32'h3d, CVR_RESP_OKAY);
    wr(`CVR_OFS_REF, 32'ha7, CVR_RESP_OKAY);
    cmp("switch", 32'h1, 32'(input_switch_o));
    sleep_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    rd(`CVR_OFS_REF, 32'ha7, CVR_RESP_OKAY);
    rd(`CVR_OFS_CMP, 32'h3d, CVR_RESP_OKAY);
    // Software powers both blocks down before the next sleep
    wr(`CVR_OFS_CMP, 32'h07, CVR_RESP_OKAY);
    wr(`CVR_OFS_REF, 32'h00, CVR_RESP_OKAY);
    sleep_i <= 1'b1;
    @(posedge ref_clk_i);
    cmp("comparators off", 32'h0, 32'(comparators_on_o));
    cmp("wake masked", 32'h0, 32'(wake_o));
    sleep_i <= 1'b0;
    // Clock enable low refuses new requests
    ce_i <= 1'b0;
    @(posedge ref_clk_i);
    cmp("frozen ready", 32'h0, 32'(s_axi_arready_o));
    ce_i <= 1'b1;
  endtask : t_sleep

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_ladder();
    t_pin();
    t_modes();
    t_flag();
    t_sleep();
    wr(8'h10, 32'h5a, CVR_RESP_SLVERR);
    rd(8'h10, 32'h0, CVR_RESP_SLVERR);
    give_verdict();
  end
endmodule : test_cvr_comparator_vref_ctrl
